// ===== src/sapc_pkg.sv
// Shared constants and types for the converter control block
package sapc_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_RESULT_LO = 16'hFF08;
    localparam logic [15:0] ADDR_RESULT_HI = 16'hFF09;
    localparam logic [15:0] ADDR_MODE      = 16'hFF28;
    localparam logic [15:0] ADDR_CHANNEL   = 16'hFF29;
    localparam logic [15:0] ADDR_CMP_MODE  = 16'hFF2A;
    localparam logic [15:0] ADDR_CMP_THR   = 16'hFF2B;

    // Field positions
    localparam int MODE_RUN_BIT   = 7;
    localparam int MODE_TIME_LSB  = 3;
    localparam int MODE_BOOST_BIT = 0;
    localparam int CMP_EN_BIT     = 7;
    localparam int CMP_POL_BIT    = 6;

    // Writable bit masks, all other bits stay zero
    localparam logic [7:0] MODE_WMASK    = 8'hB9;
    localparam logic [7:0] CHANNEL_WMASK = 8'h07;
    localparam logic [7:0] CMP_WMASK     = 8'hC0;

    // Reset values
    localparam logic [7:0] MODE_RST    = 8'h00;
    localparam logic [7:0] CHANNEL_RST = 8'h00;
    localparam logic [7:0] CMP_RST     = 8'h00;
    localparam logic [7:0] THR_RST     = 8'h00;

    // Result geometry
    localparam int RES_BITS = 10;
    localparam int RES_PAD  = 6;

    // A conversion spans twelve equal steps: two sampling, ten bit decisions
    localparam int STEPS_PER_CONV = 12;
    localparam int SAMPLE_STEPS   = 2;

    // Conversion periods in clock periods, per time code
    localparam int PERIOD_CODE0 = 288;
    localparam int PERIOD_CODE1 = 240;
    localparam int PERIOD_CODE2 = 192;
    localparam int PERIOD_CODE4 = 144;
    localparam int PERIOD_CODE5 = 120;
    localparam int PERIOD_CODE6 = 96;

    typedef enum logic [2:0] {
        SAPC_IDLE    = 3'h1,
        SAPC_SAMPLE  = 3'h2,
        SAPC_CONVERT = 3'h4
    } sapc_state_t;

    typedef struct packed {
        sapc_state_t          state;
        logic [5:0]           cnt;
        logic [3:0]           bit_idx;
        logic [RES_BITS-1:0]  sar;
        logic [RES_BITS-1:0]  tap;
        logic [RES_BITS-1:0]  result;
        logic                 done;
    } sapc_core_t;

    // Step length in clocks for a time code; prohibited codes fall back to the longest
    function automatic logic [4:0] step_of(input logic [2:0] code);
        int period;
        case (code)
            3'h0: period = PERIOD_CODE0;
            3'h1: period = PERIOD_CODE1;
            3'h2: period = PERIOD_CODE2;
            3'h4: period = PERIOD_CODE4;
            3'h5: period = PERIOD_CODE5;
            3'h6: period = PERIOD_CODE6;
            default: period = PERIOD_CODE0;
        endcase
        return 5'(period / STEPS_PER_CONV);
    endfunction

endpackage

// ===== src/sapc_core_if.sv
// Link between the register front end and the approximation sequencer
`timescale 1ns/1ps
interface sapc_core_if;
    logic                          run;
    logic                          abort;
    logic [4:0]                    step_len;
    logic                          cmp_ge;
    logic                          done;
    logic [sapc_pkg::RES_BITS-1:0] result;
    logic                          sample;
    logic [sapc_pkg::RES_BITS-1:0] tap;

    modport ctrl (output run, abort, step_len, cmp_ge, input done, result, sample, tap);
    modport core (input run, abort, step_len, cmp_ge, output done, result, sample, tap);
endinterface

// ===== src/sapc_sar_core.sv
// Successive-approximation sequencer: sampling, ten bit decisions, result hand-off
`timescale 1ns/1ps
module sapc_sar_core (
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   arst_n,
    // Front end
    sapc_core_if.core   cif
);
    sapc_pkg::sapc_core_t r_reg;
    sapc_pkg::sapc_core_t r_next;

    logic [sapc_pkg::RES_BITS-1:0] decided;
    logic [5:0]                    sample_last;
    logic [4:0]                    step_last;

    assign sample_last = 6'(sapc_pkg::SAMPLE_STEPS * cif.step_len) - 6'h01;
    assign step_last   = cif.step_len - 5'h01;

    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        decided     = r_reg.sar;
        // keep on input at or above tap
        decided[r_reg.bit_idx] = cif.cmp_ge;
        case (r_reg.state)
            sapc_pkg::SAPC_IDLE: begin
                r_next.cnt = 6'h00;
                if (cif.run) begin
                    r_next.state = sapc_pkg::SAPC_SAMPLE;
                end
            end
            sapc_pkg::SAPC_SAMPLE: begin
                r_next.cnt = r_reg.cnt + 6'h01;
                if (r_reg.cnt == sample_last) begin
                    // start at bit 9, tap half scale
                    r_next.state   = sapc_pkg::SAPC_CONVERT;
                    r_next.cnt     = 6'h00;
                    r_next.bit_idx = 4'(sapc_pkg::RES_BITS - 1);
                    r_next.sar     = '0;
                    r_next.tap     = 10'h200;
                end
            end
            sapc_pkg::SAPC_CONVERT: begin
                r_next.cnt = r_reg.cnt + 6'h01;
                if (r_reg.cnt[4:0] == step_last) begin
                    r_next.cnt = 6'h00;
                    r_next.sar = decided;
                    if (r_reg.bit_idx == 4'h0) begin
                        r_next.result = decided;
                        r_next.done   = 1'b1;
                        r_next.state  = cif.run ? sapc_pkg::SAPC_SAMPLE : sapc_pkg::SAPC_IDLE;
                    end else begin
                        r_next.bit_idx = r_reg.bit_idx - 4'h1;
                        r_next.tap     = decided;
                        r_next.tap[r_reg.bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
            default: begin
                r_next.state = sapc_pkg::SAPC_IDLE;
            end
        endcase
        if (cif.abort) begin
            r_next.state = sapc_pkg::SAPC_IDLE;
            r_next.cnt   = 6'h00;
            r_next.done  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '{state: sapc_pkg::SAPC_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign cif.done   = r_reg.done;
    assign cif.result = r_reg.result;
    assign cif.sample = (r_reg.state == sapc_pkg::SAPC_SAMPLE);
    assign cif.tap    = (r_reg.state == sapc_pkg::SAPC_CONVERT) ? r_reg.tap : '0;
endmodule

// ===== src/sapc_top.sv
// Register front end, threshold compare and analog hookup of the converter
`timescale 1ns/1ps

// What this block does
// - Result register is 16 bits, ten result bits on top, low six read zero.
// - Result register content after reset is undefined; nothing relies on it.
// - Compare enable bit 7 picks plain conversion or threshold comparison.
// - In compare mode interrupt only on match; polarity bit 6 picks >= or <.
// - Threshold compares against upper eight result bits; low two ignored.
// - Threshold takes byte writes only; compare mode bits 5 to 0 stay zero.
// - Reset clears compare mode and threshold registers to zero.
// - Result reads and mode or threshold writes insert one bus wait cycle.
// - Each conversion samples for a fixed time, then holds until the end.
// - Sequence starts with bit 9 set and the tap at half reference.
// - Lower bits trial-set in turn, kept when input is at or above tap.
// - After ten decisions result is latched and interrupt may fire together.
// - Conversions repeat back to back while the run bit stays set.
// - Writes to mode, channel, compare or threshold abort and restart.
// - Writing run to zero stops the conversion at once.
// - Without compare every conversion stores result and raises interrupt.
// - Single channel select mode: one of eight inputs is converted.
// - Channel register bits 2 to 0 pick the input; upper bits stay zero.
// - Mode register: run bit 7, boost bit 0, time code bits 5 to 3.
module sapc_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // CPU register port
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic [7:0]  cpu_wmask,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_wait,
    // Interrupt request
    output logic             conversion_done_irq,
    // Analog front end
    output logic      [2:0]  channel_sel,
    output logic             sample_hold_sample,
    output logic      [9:0]  tap_code,
    output logic             reference_boost_enable,
    input  wire logic        comparator_ge
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] channel;
        logic [7:0] cmp_mode;
        logic [7:0] cmp_thr;
        logic [9:0] result;
        logic [7:0] rdata;
        logic       wait_cyc;
        logic       irq;
        logic [1:0] cmp_sync;
    } sapc_regs_t;

    sapc_regs_t r_reg;
    sapc_regs_t r_next;

    sapc_core_if cif ();

    sapc_sar_core u_core (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .cif     (cif)
    );

    logic       hit_mode;
    logic       hit_chan;
    logic       hit_cmp;
    logic       hit_thr;
    logic       hit_res_lo;
    logic       hit_res_hi;
    logic       ctrl_write;
    logic [7:0] upper_res;
    logic       match;

    assign hit_mode   = (cpu_addr == sapc_pkg::ADDR_MODE);
    assign hit_chan   = (cpu_addr == sapc_pkg::ADDR_CHANNEL);
    assign hit_cmp    = (cpu_addr == sapc_pkg::ADDR_CMP_MODE);
    assign hit_thr    = (cpu_addr == sapc_pkg::ADDR_CMP_THR);
    assign hit_res_lo = (cpu_addr == sapc_pkg::ADDR_RESULT_LO);
    assign hit_res_hi = (cpu_addr == sapc_pkg::ADDR_RESULT_HI);

    assign ctrl_write = cpu_wr & (hit_mode | hit_chan | hit_cmp | hit_thr);

    assign upper_res = cif.result[sapc_pkg::RES_BITS-1 -: 8];

    assign match = r_reg.cmp_mode[sapc_pkg::CMP_POL_BIT] ? (upper_res < r_reg.cmp_thr)
                                                         : (upper_res >= r_reg.cmp_thr);

    always_comb begin
        r_next          = r_reg;
        r_next.wait_cyc = 1'b0;
        r_next.irq      = 1'b0;
        // Comparator crosses from the analog side; only the second stage is used
        r_next.cmp_sync = {r_reg.cmp_sync[0], comparator_ge};

        // Mode, channel and compare bit writes merge through the mask; unused bits are forced low
        if (cpu_wr) begin
            if (hit_mode) begin
                r_next.mode = ((r_reg.mode & ~cpu_wmask) | (cpu_wdata & cpu_wmask))
                              & sapc_pkg::MODE_WMASK;
            end
            if (hit_chan) begin
                r_next.channel = ((r_reg.channel & ~cpu_wmask) | (cpu_wdata & cpu_wmask))
                                 & sapc_pkg::CHANNEL_WMASK;
            end
            // compare mode low bits held zero
            if (hit_cmp) begin
                r_next.cmp_mode = ((r_reg.cmp_mode & ~cpu_wmask) | (cpu_wdata & cpu_wmask))
                                  & sapc_pkg::CMP_WMASK;
            end
            if (hit_thr && (cpu_wmask == 8'hFF)) begin
                r_next.cmp_thr = cpu_wdata;
            end
            if (hit_mode || hit_cmp || hit_thr || hit_chan) begin
                r_next.wait_cyc = 1'b1;
            end
        end

        if (cpu_rd) begin
            r_next.rdata = 8'h00;
            case (1'b1)
                // high byte holds upper eight bits
                hit_res_hi: r_next.rdata = r_reg.result[9:2];
                hit_res_lo: r_next.rdata = {r_reg.result[1:0], {sapc_pkg::RES_PAD{1'b0}}};
                hit_mode:   r_next.rdata = r_reg.mode;
                hit_chan:   r_next.rdata = r_reg.channel;
                hit_cmp:    r_next.rdata = r_reg.cmp_mode;
                hit_thr:    r_next.rdata = r_reg.cmp_thr;
                default:    r_next.rdata = 8'h00;
            endcase
            if (hit_res_lo || hit_res_hi) begin
                r_next.wait_cyc = 1'b1;
            end
        end

        if (cif.done) begin
            r_next.result = cif.result;
            r_next.irq = !r_reg.cmp_mode[sapc_pkg::CMP_EN_BIT] || match;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            // result value carries no meaning here
            r_reg <= '{mode:     sapc_pkg::MODE_RST,
                       channel:  sapc_pkg::CHANNEL_RST,
                       cmp_mode: sapc_pkg::CMP_RST,
                       cmp_thr:  sapc_pkg::THR_RST,
                       default:  '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign cif.run      = r_reg.mode[sapc_pkg::MODE_RUN_BIT];
    // Abort lasts one cycle; the sequencer restarts from idle next cycle if run is set
    assign cif.abort    = ctrl_write;
    assign cif.step_len = sapc_pkg::step_of(r_reg.mode[sapc_pkg::MODE_TIME_LSB +: 3]);
    assign cif.cmp_ge   = r_reg.cmp_sync[1];

    assign cpu_rdata              = r_reg.rdata;
    assign cpu_wait               = r_reg.wait_cyc;
    assign conversion_done_irq    = r_reg.irq;
    assign channel_sel            = r_reg.channel[2:0];
    assign sample_hold_sample     = cif.sample;
    assign tap_code               = cif.tap;
    assign reference_boost_enable = r_reg.mode[sapc_pkg::MODE_BOOST_BIT];
endmodule

// ===== tb/sapc_monitor.sv
// Port-level checks for the converter control block
`timescale 1ns/1ps
module sapc_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        arst_n,
    // CPU register port
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_wmask,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        cpu_wait,
    // Interrupt and analog side
    input wire logic        conversion_done_irq,
    input wire logic [2:0]  channel_sel,
    input wire logic        sample_hold_sample,
    input wire logic [9:0]  tap_code,
    input wire logic        reference_boost_enable,
    input wire logic        comparator_ge
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic ctl_wr;
    logic mode_wr;
    // Writes to FF28..FF2B
    assign ctl_wr  = cpu_wr && cpu_addr[15:2] == 14'h3FCA;
    assign mode_wr = ctl_wr && cpu_addr == sapc_pkg::ADDR_MODE && cpu_wmask == 8'hFF;
    a_wait_write: assert property (ctl_wr |=> cpu_wait)
        else $error("no wait after control write");
    a_wait_read: assert property (cpu_rd && cpu_addr[15:1] == 15'h7F84 |=> cpu_wait)
        else $error("no wait after result read");
    a_low_zero: assert property (cpu_rd && cpu_addr == sapc_pkg::ADDR_RESULT_LO
        |=> cpu_rdata[5:0] == 6'h00)
        else $error("low result bits not zero");
    a_abort_idle: assert property (ctl_wr |-> ##1 !sample_hold_sample)
        else $error("write did not abort");
    a_stop_quiet: assert property (mode_wr && !cpu_wdata[7]
        |-> ##3 (!sample_hold_sample && !conversion_done_irq) [*8])
        else $error("conversion kept running");
    a_half_tap: assert property ($fell(sample_hold_sample) && !$past(cpu_wr)
        && !$past(cpu_wr, 2) |-> tap_code == 10'h200)
        else $error("first tap not half scale");
    a_boost_mode: assert property (mode_wr
        |=> reference_boost_enable == $past(cpu_wdata[0]))
        else $error("boost does not follow mode");
    a_chan_follow: assert property (cpu_wr && cpu_addr == sapc_pkg::ADDR_CHANNEL
        && cpu_wmask == 8'hFF |=> channel_sel == $past(cpu_wdata[2:0]))
        else $error("channel does not follow write");
    a_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq [*8])
        else $error("done pulse too long or too close");
    c_irq: cover property (conversion_done_irq);
    c_abort: cover property (ctl_wr ##1 !sample_hold_sample);
    c_hold: cover property ($fell(sample_hold_sample));
endmodule

bind sapc_top sapc_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait), .conversion_done_irq(conversion_done_irq),
    .channel_sel(channel_sel), .sample_hold_sample(sample_hold_sample),
    .tap_code(tap_code), .reference_boost_enable(reference_boost_enable),
    .comparator_ge(comparator_ge));

// ===== tb/sapc_analog_model.sv
// Behavioural analog front end: input select, sample-and-hold, comparator
`timescale 1ns/1ps
module sapc_analog_model (
    // Input levels as ideal codes
    input  wire logic [9:0] vin [8],
    // Control from the block
    input  wire logic       ref_clk,
    input  wire logic [2:0] channel_sel,
    input  wire logic       sample_hold_sample,
    input  wire logic [9:0] tap_code,
    // Comparator result
    output logic            comparator_ge
);
    logic [9:0] held = 10'h000;
    // Tracks while sampling; a late channel change after hold is not seen
    always @(posedge ref_clk) if (sample_hold_sample) held <= vin[channel_sel];
    assign comparator_ge = held >= tap_code;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
    logic        ref_clk, arst_n, cpu_wr, cpu_rd, cpu_wait, irq, smp, boost, ge, wt;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_wmask, cpu_rdata, rv;
    logic [2:0]  chan;
    logic [9:0]  tap;
    logic [9:0]  vin [8];
    int          n_errors = 0, compares = 0, n;
    int          codes [6] = '{0, 1, 2, 4, 5, 6};
    int          pers [6] = '{288, 240, 192, 144, 120, 96};

    sapc_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait), .conversion_done_irq(irq),
        .channel_sel(chan), .sample_hold_sample(smp), .tap_code(tap),
        .reference_boost_enable(boost), .comparator_ge(ge));
    sapc_analog_model afe (.vin(vin), .ref_clk(ref_clk), .channel_sel(chan),
        .sample_hold_sample(smp), .tap_code(tap), .comparator_ge(ge));

    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic stop_test();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t data %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_errors++;
            $display("[FAIL] %0t count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge ref_clk);
        cpu_addr <= a; cpu_wdata <= d; cpu_wmask <= m; cpu_wr <= 1'b1;
        @(posedge ref_clk);
        cpu_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        cpu_addr <= a; cpu_rd <= 1'b1;
        @(posedge ref_clk);
        cpu_rd <= 1'b0;
        #1 rv = cpu_rdata;
        wt = cpu_wait;
    endtask
    // Counts cycles up to the next done pulse and judges whether one came
    task automatic wait_irq(input int lim, input int want);
        n = 0;
        while (n < lim) begin
            @(posedge ref_clk);
            #1;
            if (irq === 1'b1) break;
            n++;
        end
        chkn(int'(n < lim), want);
    endtask
    task automatic t_regs();
        rd(16'hFF2A); chk8(rv, 8'h00);
        rd(16'hFF2B); chk8(rv, 8'h00);
        rd(16'hFF28); chk8(rv, 8'h00);
        rd(16'hFF29); chk8(rv, 8'h00);
        rd(16'hFF00); chk8(rv, 8'h00);
        wr(16'hFF2A, 8'hFF, 8'hFF); rd(16'hFF2A); chk8(rv, 8'hC0);
        wr(16'hFF2A, 8'h00, 8'h80); rd(16'hFF2A); chk8(rv, 8'h40);
        wr(16'hFF2B, 8'h5A, 8'h01); rd(16'hFF2B); chk8(rv, 8'h00);
        wr(16'hFF2B, 8'h5A, 8'hFF); rd(16'hFF2B); chk8(rv, 8'h5A);
        wr(16'hFF29, 8'hFF, 8'hFF); rd(16'hFF29); chk8(rv, 8'h07);
        wr(16'hFF28, 8'h7E, 8'hFF); rd(16'hFF28); chk8(rv, 8'h38);
        wr(16'hFF2A, 8'h00, 8'hFF);
        wr(16'hFF2B, 8'h00, 8'hFF);
    endtask
    task automatic t_plain();
        wr(16'hFF29, 8'h03, 8'hFF);
        wr(16'hFF28, 8'h01, 8'hFF);
        repeat (1750) @(posedge ref_clk);
        wr(16'hFF28, 8'hB1, 8'hFF);
        wait_irq(300, 1);
        wait_irq(300, 1); chkn(n + 1, 96);
        rd(16'hFF09); chk8(rv, vin[3][9:2]);
        chk8({7'h00, wt}, 8'h01);
        rd(16'hFF08); chk8(rv, {vin[3][1:0], 6'h00});
    endtask
    task automatic t_codes();
        for (int i = 0; i < 6; i++) begin
            wr(16'hFF28, 8'h01, 8'hFF);
            // Stay stopped a while so the stop is seen to hold
            repeat (10) @(posedge ref_clk);
            wr(16'hFF28, 8'h81 | 8'(codes[i] << 3), 8'hFF);
            wait_irq(400, 1);
            wait_irq(400, 1); chkn(n + 1, pers[i]);
        end
    endtask
    task automatic t_abort();
        wait_irq(300, 1);
        rd(16'hFF09); chk8(rv, vin[3][9:2]);
        repeat (30) @(posedge ref_clk);
        wr(16'hFF29, 8'h05, 8'hFF);
        wait_irq(300, 1); rd(16'hFF09); chk8(rv, vin[5][9:2]);
        repeat (40) @(posedge ref_clk);
        wr(16'hFF28, 8'h31, 8'hFF);
        wait_irq(400, 0);
        wr(16'hFF28, 8'hB1, 8'hFF);
        wait_irq(300, 1);
    endtask
    task automatic t_cmp();
        wr(16'hFF29, 8'h02, 8'hFF);
        wr(16'hFF2B, 8'hAA, 8'hFF);
        wr(16'hFF2A, 8'h80, 8'hFF);
        wait_irq(300, 1); rd(16'hFF09); chk8(rv, 8'hAA);
        wr(16'hFF2B, 8'hAB, 8'hFF);
        wait_irq(400, 0);
        wr(16'hFF2A, 8'hC0, 8'hFF);
        wait_irq(300, 1);
        wr(16'hFF2B, 8'hAA, 8'hFF);
        wait_irq(400, 0);
        wr(16'hFF2A, 8'h00, 8'hFF);
        wait_irq(300, 1);
    endtask
    // Reset in mid-run must clear the compare registers and stop conversions
    task automatic t_reset();
        wr(16'hFF2A, 8'hC0, 8'hFF);
        wr(16'hFF2B, 8'h77, 8'hFF);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(16'hFF2A); chk8(rv, 8'h00);
        rd(16'hFF2B); chk8(rv, 8'h00);
        wait_irq(400, 0);
    endtask

    initial begin
        vin = '{10'h0C5, 10'h155, 10'h2AB, 10'h3A7, 10'h04E, 10'h1F3, 10'h31C, 10'h27A};
        arst_n = 0; cpu_wr = 0; cpu_rd = 0;
        cpu_addr = 16'h0000; cpu_wdata = 8'h00; cpu_wmask = 8'h00;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs();
        t_plain();
        t_codes();
        t_abort();
        t_cmp();
        t_reset();
        stop_test();
    end
    initial begin
        #150000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
endmodule
